//--- xmb_chk.sv
// xmb_chk: timing checker on the xmb_ctrl request port and pins
// assumes registers change only through reg_wr_in
`default_nettype none
module xmb_chk
   import xmb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire xmb_req_t req_in,
   input wire logic busy_out,
   input wire logic [7:0] port_a_output_in,
   input wire logic [7:0] port_a_direction_in,
   input wire xmb_pins_t pins_out
);
   logic [7:0] mc_reg, xa_reg, xb_reg, mc_next, xa_next, xb_next;
   logic [1:0] w_reg, w_next, wsel;
   logic [2:0] n_reg, n_next;
   logic nr_reg, nr_next, sb;
   assign sb = pins_out.read_strobe_b & pins_out.write_strobe_b;
   assign wsel = (req_in.addr >= {xa_reg[6:4], 13'h0000}) ?
      {xa_reg[1], mc_reg[6]} : xa_reg[3:2];
   always_comb begin
      mc_next = mc_reg;
      xa_next = xa_reg;
      xb_next = xb_reg;
      w_next = w_reg;
      nr_next = nr_reg;
      // strobe low cycles, read at the rising edge of the strobe
      n_next = sb ? 3'h0 : n_reg + 3'h1;
      if (req_in.valid && !busy_out) begin
         w_next = wsel;
         nr_next = req_in.next_is_ram;
      end
      if (reg_wr_in && reg_addr_in == MCU_CONTROL_ADDR) mc_next = reg_wdata_in;
      if (reg_wr_in && reg_addr_in == EXT_MEM_CONTROL_A_ADDR)
         xa_next = reg_wdata_in & XA_WRITE_MASK;
      if (reg_wr_in && reg_addr_in == EXT_MEM_CONTROL_B_ADDR)
         xb_next = reg_wdata_in & XB_WRITE_MASK;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         {mc_reg, xa_reg, xb_reg, w_reg, n_reg, nr_reg} <= '0;
      end else begin
         {mc_reg, xa_reg, xb_reg} <= {mc_next, xa_next, xb_next};
         {w_reg, n_reg, nr_reg} <= {w_next, n_next, nr_next};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   int_quiet_a: assert property (
      req_in.valid && !busy_out && req_in.addr < EXT_BASE_NORMAL
      |=> !busy_out && sb) else $error("internal access went out");
   off_quiet_a: assert property (
      !mc_reg[7] && req_in.valid |=> !busy_out && sb)
      else $error("access while disabled");
   off_pins_a: assert property (
      !mc_reg[7] && $stable(mc_reg) && $past(rst_b_in) &&
      $stable({port_a_direction_in, port_a_output_in}) |->
      !pins_out.ctl_oe && pins_out.ad_oe == port_a_direction_in &&
      pins_out.ad_out == port_a_output_in) else $error("pins not port");
   on_pins_a: assert property (
      mc_reg[7] && $past(mc_reg[7]) |-> pins_out.ctl_oe)
      else $error("strobe pins not driven");
   addr_first_a: assert property (
      $rose(busy_out) && xb_reg[2:0] == 3'h0 |-> pins_out.latch_strobe &&
      {pins_out.hi_out, pins_out.ad_out} == req_in.addr
      ##1 !pins_out.latch_strobe && sb) else $error("address phase wrong");
   setup_data_a: assert property (
      $rose(busy_out) |=> pins_out.ad_oe == {8{req_in.write}} &&
      (!req_in.write || pins_out.ad_out == req_in.wdata))
      else $error("data phase wrong");
   strobe_len_a: assert property (
      $rose(sb) |-> busy_out && n_reg == ((w_reg == WAIT_TWO_IDLE) ?
      3'h3 : {1'b0, w_reg} + 3'h1)) else $error("strobe length wrong");
   trail_latch_a: assert property (
      $rose(sb) |-> pins_out.latch_strobe == nr_reg)
      else $error("trailing latch pulse wrong");
   busy_end_a: assert property (
      $rose(sb) |=> if (w_reg == WAIT_TWO_IDLE) (busy_out ##1 !busy_out)
      else !busy_out) else $error("access end wrong");
   keeper_a: assert property (
      $stable(xb_reg) |-> pins_out.bus_hold_enable == xb_reg[7])
      else $error("bus keeper enable wrong");
endmodule // xmb_chk
bind xmb_ctrl xmb_chk chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .req_in(req_in), .busy_out(busy_out),
   .port_a_output_in(port_a_output_in),
   .port_a_direction_in(port_a_direction_in), .pins_out(pins_out));
`default_nettype wire

//--- xmb_ctrl.sv
// xmb_ctrl: external memory bus sequencer with its control registers
// assumes cpu requests held stable while busy; pins are merged with port
// logic here and resolved to the pad by the surrounding io ring
//
// Contract
// - four software-selected wait settings serve slower external memories
// - external space splits into two sectors with independent waits
// - upper sector uses upper wait bits, lower sector lower wait bits
// - trailing latch pulse only if next access is RAM, later per wait
// - strobes made from cpu clock; far side treats bus as asynchronous
// - addresses below 0x1100 never start an external access outside legacy mode (legacy: from 0x1000)
// - legacy mode: internal region 4096 bytes, external from 0x1000
// - enable bit gives address, data, latch and strobe pins to interface
// - enabled interface overrides port direction registers on its pins
// - clearing enable returns pins to normal port value and direction
// - legacy mode wait bit adds exactly one strobe cycle
// - second control register top bit reads zero; software writes zero
// - wait codes: none, one, two, or two plus an idle cycle
// - sector field sets boundary in 8 Kbyte steps; zero means one sector
// - mask field releases zero to seven high address pins from the top
// - bus keeper follows only its own enable bit
`default_nettype none
module xmb_ctrl
   import xmb_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // strap
   input wire logic legacy_mode_in,
   // register access port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // cpu data-space request
   input wire xmb_req_t req_in,
   output logic busy_out,
   output logic rdata_valid_out,
   output logic [7:0] rdata_out,
   // port registers behind the shared pins
   input wire logic [7:0] port_a_output_in,
   input wire logic [7:0] port_a_direction_in,
   input wire logic [7:0] port_c_output_in,
   input wire logic [7:0] port_c_direction_in,
   // pads
   input wire logic [7:0] muxed_addr_data_in,
   output xmb_pins_t pins_out
);
   logic [7:0] mcu_reg, mcu_next;
   logic [7:0] xa_reg, xa_next;
   logic [7:0] xb_reg, xb_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [7:0] pin_sync1_reg, pin_sync2_reg, pin_sync3_reg;
   logic legacy_reg, legacy_next;
   logic strap_taken_reg;
   xmb_state_t state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [1:0] wait_reg, wait_next;
   logic write_reg, write_next;
   logic trail_reg, trail_next;
   logic [15:0] addr_reg, addr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic busy_reg, busy_next;
   logic rvalid_reg, rvalid_next;
   logic [7:0] dout_reg, dout_next;
   xmb_pins_t pins_reg, pins_next;

   logic enable;
   logic is_ext;
   logic upper;
   logic [1:0] sel_wait;
   logic [7:0] hi_keep;
   logic [15:0] sector_base;
   logic [1:0] strobe_len;

   assign enable = mcu_reg[MCU_ENABLE_BIT];
   // strobe cycles beyond the first, by wait code
   assign strobe_len = (wait_reg == WAIT_NONE) ? 2'h0 :
                       (wait_reg == WAIT_ONE) ? 2'h1 : 2'h2;

   // address decode and wait selection
   always_comb begin
      sector_base = {xa_reg[XA_SECTOR_LSB +: 3], 13'h0000};
      if (legacy_reg)
         is_ext = req_in.addr >= EXT_BASE_LEGACY;
      else
         is_ext = req_in.addr >= EXT_BASE_NORMAL;
      upper = (sector_base == 16'h0000) || (req_in.addr >= sector_base);
      if (legacy_reg)
         sel_wait = {1'b0, mcu_reg[MCU_UPPER_WAIT_LO_BIT]};
      else if (upper)
         sel_wait = {xa_reg[XA_UPPER_WAIT_HI_BIT],
                     mcu_reg[MCU_UPPER_WAIT_LO_BIT]};
      else
         sel_wait = xa_reg[XA_LOWER_WAIT_LSB +: 2];
   end

   // high address pins kept by the bus, released from the top
   generate
      for (genvar i = 0; i < 8; i++) begin : g_hi
         assign hi_keep[i] = legacy_reg ||
            (32'(i) < 32'(8 - int'(xb_reg[XB_RELEASE_LSB +: 3])));
      end
   endgenerate

   // register file
   always_comb begin
      mcu_next = mcu_reg;
      xa_next = xa_reg;
      xb_next = xb_reg;
      rdata_next = rdata_reg;
      // strap is caught once, in the first cycle after reset release
      legacy_next = strap_taken_reg ? legacy_reg : legacy_mode_in;
      if (reg_wr_in) begin
         case (reg_addr_in)
            MCU_CONTROL_ADDR: mcu_next = reg_wdata_in & MCU_WRITE_MASK;
            EXT_MEM_CONTROL_A_ADDR: begin
               if (!legacy_reg)
                  xa_next = reg_wdata_in & XA_WRITE_MASK;
            end
            EXT_MEM_CONTROL_B_ADDR: begin
               if (!legacy_reg)
                  xb_next = reg_wdata_in & XB_WRITE_MASK;
            end
            default: ;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            MCU_CONTROL_ADDR: rdata_next = mcu_reg;
            EXT_MEM_CONTROL_A_ADDR: rdata_next = xa_reg;
            EXT_MEM_CONTROL_B_ADDR: rdata_next = xb_reg;
            default: rdata_next = REG_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         mcu_reg <= REG_RESET;
         xa_reg <= REG_RESET;
         xb_reg <= REG_RESET;
         rdata_reg <= REG_RESET;
         legacy_reg <= 1'b0;
      end else begin
         mcu_reg <= mcu_next;
         xa_reg <= xa_next;
         xb_reg <= xb_next;
         rdata_reg <= rdata_next;
         legacy_reg <= legacy_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         strap_taken_reg <= 1'b0;
      else
         strap_taken_reg <= 1'b1;
   end

   // read data pad sync: three flops, change counts when last two agree
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         pin_sync1_reg <= REG_RESET;
         pin_sync2_reg <= REG_RESET;
         pin_sync3_reg <= REG_RESET;
      end else begin
         pin_sync1_reg <= muxed_addr_data_in;
         pin_sync2_reg <= pin_sync1_reg;
         pin_sync3_reg <= pin_sync2_reg;
      end
   end

   // access sequencer; all strobes derive from clk_in alone
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      wait_next = wait_reg;
      write_next = write_reg;
      trail_next = trail_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      busy_next = busy_reg;
      rvalid_next = 1'b0;
      dout_next = dout_reg;
      case (state_reg)
         ST_IDLE: begin
            if (req_in.valid && enable && is_ext) begin
               state_next = ST_ADDR;
               busy_next = 1'b1;
               wait_next = sel_wait;
               write_next = req_in.write;
               trail_next = req_in.next_is_ram;
               addr_next = req_in.addr;
               wdata_next = req_in.wdata;
            end
         end
         ST_ADDR: state_next = ST_SETUP;
         ST_SETUP: begin
            state_next = ST_STROBE;
            cnt_next = 2'h0;
         end
         ST_STROBE: begin
            if (cnt_reg == strobe_len) begin
               state_next = ST_TRAIL;
            end else begin
               cnt_next = cnt_reg + 2'h1;
            end
         end
         ST_TRAIL: begin
            // pad data lags three flops, so it is taken here; only the
            // longest strobe leaves it settled in the chain by now
            if (!write_reg) begin
               rvalid_next = 1'b1;
               if (pin_sync2_reg == pin_sync3_reg)
                  dout_next = pin_sync3_reg;
            end
            if (wait_reg == WAIT_TWO_IDLE) begin
               state_next = ST_GAP;
            end else begin
               state_next = ST_IDLE;
               busy_next = 1'b0;
            end
         end
         ST_GAP: begin
            state_next = ST_IDLE;
            busy_next = 1'b0;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // pin drive: interface overrides ports while enabled
   always_comb begin
      pins_next.bus_hold_enable = xb_reg[XB_HOLD_BIT];
      pins_next.ad_out = port_a_output_in;
      pins_next.ad_oe = port_a_direction_in;
      pins_next.hi_out = port_c_output_in;
      pins_next.hi_oe = port_c_direction_in;
      pins_next.latch_strobe = 1'b0;
      pins_next.read_strobe_b = 1'b1;
      pins_next.write_strobe_b = 1'b1;
      pins_next.ctl_oe = enable;
      if (enable) begin
         pins_next.ad_oe = ALL_ONES_BYTE;
         pins_next.ad_out = addr_reg[7:0];
         for (int k = 0; k < 8; k++) begin
            if (hi_keep[k]) begin
               pins_next.hi_out[k] = addr_reg[8 + k];
               pins_next.hi_oe[k] = 1'b1;
            end
         end
         case (state_next)
            ST_ADDR: pins_next.latch_strobe = 1'b1;
            ST_STROBE: begin
               if (write_next) begin
                  pins_next.ad_out = wdata_next;
                  pins_next.write_strobe_b = 1'b0;
               end else begin
                  pins_next.ad_oe = 8'h00;
                  pins_next.read_strobe_b = 1'b0;
               end
            end
            ST_SETUP: begin
               pins_next.ad_out = wdata_next;
               if (!write_next)
                  pins_next.ad_oe = 8'h00;
            end
            ST_TRAIL: pins_next.latch_strobe = trail_next;
            default: ;
         endcase
         if (state_next == ST_ADDR) begin
            pins_next.ad_out = addr_next[7:0];
            for (int k = 0; k < 8; k++)
               if (hi_keep[k])
                  pins_next.hi_out[k] = addr_next[8 + k];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
         wait_reg <= WAIT_NONE;
         write_reg <= 1'b0;
         trail_reg <= 1'b0;
         addr_reg <= 16'h0000;
         wdata_reg <= REG_RESET;
         busy_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         dout_reg <= REG_RESET;
         pins_reg <= '{ad_out: 8'h00, ad_oe: 8'h00, hi_out: 8'h00,
                       hi_oe: 8'h00, latch_strobe: 1'b0,
                       read_strobe_b: 1'b1, write_strobe_b: 1'b1,
                       ctl_oe: 1'b0, bus_hold_enable: 1'b0};
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         wait_reg <= wait_next;
         write_reg <= write_next;
         trail_reg <= trail_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         busy_reg <= busy_next;
         rvalid_reg <= rvalid_next;
         dout_reg <= dout_next;
         pins_reg <= pins_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign busy_out = busy_reg;
   assign rdata_valid_out = rvalid_reg;
   assign rdata_out = dout_reg;
   assign pins_out = pins_reg;
endmodule // xmb_ctrl
`default_nettype wire

//--- xmb_ctrl_test.sv
// xmb_ctrl_test: directed bench for xmb_ctrl with an sram on its pins
// assumes one 100 MHz clock; inputs move 1 ns after each rising edge
`default_nettype none
module xmb_ctrl_test
   import xmb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic [7:0] rdata_out, ad_in, pc_o = 8'h00, pc_d = 8'h4f;
   logic [7:0] pa_o = 8'ha5, pa_d = 8'h5a;
   logic busy_out, rdata_valid_out;
   xmb_req_t req_in = '0;
   xmb_pins_t pins_out;
   int n_mismatch = 0, total_checks = 0;
   always #5 clk_in = ~clk_in;
   xmb_ctrl uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .legacy_mode_in(1'b0),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .req_in(req_in), .busy_out(busy_out), .rdata_valid_out(rdata_valid_out),
      .rdata_out(rdata_out), .port_a_output_in(pa_o),
      .port_a_direction_in(pa_d), .port_c_output_in(pc_o),
      .port_c_direction_in(pc_d), .muxed_addr_data_in(ad_in),
      .pins_out(pins_out));
   xmb_sram_model mdl (.pins_in(pins_out), .ad_out(ad_in));
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // each register task spends two cycles so no strobe is set twice at once
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(posedge clk_in) #1;
      reg_wr_in = 1'b0;
      @(posedge clk_in) #1;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(posedge clk_in) #1;
      reg_rd_in = 1'b0;
      @(posedge clk_in) #1;
      d = reg_rdata_out;
   endtask
   // busy cycles: address, setup, 1+n strobe (n = code, at most 2), trail, plus gap for code 3
   task automatic acc(logic w, logic [15:0] a, logic [7:0] d, logic nr,
      int cyc, output logic [7:0] q);
      int n;
      int nv;
      n = 0;
      nv = 0;
      req_in = '{1'b1, w, a, d, nr};
      @(posedge clk_in) #1;
      while (busy_out === 1'b1 && n < 12) begin
         n++;
         nv += int'(rdata_valid_out === 1'b1);
         @(posedge clk_in) #1;
      end
      nv += int'(rdata_valid_out === 1'b1);
      req_in.valid = 1'b0;
      q = rdata_out;
      chk("busy cycles", 16'(cyc), 16'(n));
      chk("read valid", 16'(!w && cyc > 0), 16'(nv));
      @(posedge clk_in) #1;
   endtask
   // shorter strobes leave the pad synchroniser stale: data judged at code 3
   task automatic wrd(logic [15:0] a, logic [7:0] d, logic nr, int cyc);
      logic [7:0] q;
      acc(1'b1, a, d, nr, cyc, q);
      acc(1'b0, a, 8'h00, ~nr, cyc, q);
      if (cyc > 6) chk("read data", {8'h00, d}, {8'h00, q});
   endtask
   task automatic t_regs;
      logic [7:0] q;
      logic [7:0] ad [4] = '{8'h55, 8'h6d, 8'h6c, 8'h6b};
      logic [7:0] mk [4] = '{MCU_WRITE_MASK, XA_WRITE_MASK, XB_WRITE_MASK,
         8'h00};
      for (int i = 0; i < 4; i++) begin
         rd(ad[i], q);
         chk("reg reset", {8'h00, REG_RESET}, {8'h00, q});
         wr(ad[i], 8'hff);
         rd(ad[i], q);
         chk("reg ones", {8'h00, mk[i]}, {8'h00, q});
         wr(ad[i], 8'h00);
      end
   endtask
   task automatic t_gate;
      logic [7:0] q;
      acc(1'b0, 16'h8000, 8'h00, 1'b0, 0, q);
      chk("ad_oe off", {8'h00, pa_d}, {8'h00, pins_out.ad_oe});
      wr(MCU_CONTROL_ADDR, 8'h80);
      acc(1'b1, 16'h10ff, 8'h11, 1'b1, 0, q);
      chk("ctl_oe on", 16'h0001, 16'(pins_out.ctl_oe));
   endtask
   task automatic t_waits;
      logic [1:0] lw;
      for (int c = 0; c < 4; c++) begin
         lw = 2'(3 - c);
         wr(MCU_CONTROL_ADDR, {1'b1, c[0], 6'h00});
         wr(EXT_MEM_CONTROL_A_ADDR, {4'h4, lw, c[1], 1'b0});
         wrd(16'h8000 + 16'(c), 8'(8'h3c + c), c[0], 4 + c);
         wrd(16'h7fff - 16'(c), 8'(8'hc3 - c), c[1], 7 - c);
      end
   endtask
   task automatic t_mask;
      logic [7:0] q;
      wr(EXT_MEM_CONTROL_A_ADDR, 8'h00);
      wr(MCU_CONTROL_ADDR, 8'h80);
      wr(EXT_MEM_CONTROL_B_ADDR, 8'h83);
      chk("hi_oe", 16'h005f, {8'h00, pins_out.hi_oe});
      acc(1'b1, 16'h2001, 8'haa, 1'b0, 4, q);
      chk("low bottom", 16'h00aa, {8'h00, mdl.mem[16'h0001]});
      wr(EXT_MEM_CONTROL_B_ADDR, 8'h80);
      acc(1'b1, 16'h2001, 8'h55, 1'b0, 4, q);
      chk("full addr", 16'h0055, {8'h00, mdl.mem[16'h2001]});
      wr(MCU_CONTROL_ADDR, 8'h00);
      chk("keeper", 16'h0001, 16'(pins_out.bus_hold_enable));
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      #1;
      rst_b_in = 1'b1;
      t_regs;
      t_gate;
      t_waits;
      t_mask;
      stop_test;
   end
   initial begin
      #50000;
      n_mismatch++;
      stop_test;
   end
endmodule // xmb_ctrl_test
`default_nettype wire

//--- xmb_pkg.sv
// xmb_pkg: constants and carrier types for the external memory bus block
// assumes a single cpu_clock domain; register offsets are data-space addresses
`default_nettype none
package xmb_pkg;
   localparam logic [7:0] MCU_CONTROL_ADDR = 8'h55;
   localparam logic [7:0] EXT_MEM_CONTROL_A_ADDR = 8'h6d;
   localparam logic [7:0] EXT_MEM_CONTROL_B_ADDR = 8'h6c;
   localparam logic [7:0] REG_RESET = 8'h00;
   // mcu_control fields
   localparam int MCU_ENABLE_BIT = 7;
   localparam int MCU_UPPER_WAIT_LO_BIT = 6;
   localparam logic [7:0] MCU_WRITE_MASK = 8'hff;
   // ext_mem_control_a fields
   localparam int XA_SECTOR_LSB = 4;
   localparam int XA_LOWER_WAIT_LSB = 2;
   localparam int XA_UPPER_WAIT_HI_BIT = 1;
   localparam logic [7:0] XA_WRITE_MASK = 8'h7e;
   // ext_mem_control_b fields
   localparam int XB_HOLD_BIT = 7;
   localparam int XB_RELEASE_LSB = 0;
   localparam logic [7:0] XB_WRITE_MASK = 8'h87;
   // internal memory boundaries
   localparam logic [15:0] EXT_BASE_NORMAL = 16'h1100;
   localparam logic [15:0] EXT_BASE_LEGACY = 16'h1000;
   // wait settings
   localparam logic [1:0] WAIT_NONE = 2'h0;
   localparam logic [1:0] WAIT_ONE = 2'h1;
   localparam logic [1:0] WAIT_TWO = 2'h2;
   localparam logic [1:0] WAIT_TWO_IDLE = 2'h3;
   localparam logic [7:0] ALL_ONES_BYTE = 8'hff;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic next_is_ram;
   } xmb_req_t;

   typedef struct packed {
      logic [7:0] ad_out;
      logic [7:0] ad_oe;
      logic [7:0] hi_out;
      logic [7:0] hi_oe;
      logic latch_strobe;
      logic read_strobe_b;
      logic write_strobe_b;
      logic ctl_oe;
      logic bus_hold_enable;
   } xmb_pins_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_SETUP = 6'b000100,
      ST_STROBE = 6'b001000,
      ST_TRAIL = 6'b010000,
      ST_GAP = 6'b100000
   } xmb_state_t;
endpackage : xmb_pkg
`default_nettype wire

//--- xmb_sram_model.sv
// xmb_sram_model: byte sram behind a transparent address latch
// assumes the pad level is resolved here from ad_oe of the design
`default_nettype none
module xmb_sram_model
   import xmb_pkg::*;
(
   input wire xmb_pins_t pins_in,
   output logic [7:0] ad_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [15:0]];
   logic [7:0] lat = 8'h00, wd = 8'h00, drv = 8'h00;
   logic [15:0] wa = 16'h0000;
   logic rd_q = 1'b1;
   // pin changes only: no cpu clock reaches this side
   always @(pins_in) begin
      if (pins_in.latch_strobe) lat = pins_in.ad_out;
      if (!pins_in.write_strobe_b) begin
         wa = {pins_in.hi_out, lat};
         wd = pins_in.ad_out;
      end
      if (!pins_in.read_strobe_b) drv = mem[{pins_in.hi_out, lat}];
      else if (!rd_q) drv = ~drv; // released bus has no pull
      rd_q = pins_in.read_strobe_b;
   end
   always @(posedge pins_in.write_strobe_b) mem[wa] = wd;
   assign ad_out = (pins_in.ad_oe & pins_in.ad_out) | (~pins_in.ad_oe & drv);
endmodule // xmb_sram_model
`default_nettype wire
